// *** dv/dma_far_side.sv ***
/*
 * Far side of the dma unit: memory that answers each transfer after one
 * or four cycles, failing addresses with bit 31 set, and one peripheral.
 * Assumes the unit's clock and reset.
 */
`timescale 1ns/1ps
module dma_far_side #(
    parameter int unsigned PERIPHERAL_IDENTIFIER = 5
) (
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    input  wire logic                      want,
    input  wire logic                      slow,
    input  wire logic                      xfer_valid,
    input  peripheral_dma_pkg::xfer_req_t  xfer_req,
    input  wire logic [63:0]               periph_ack,
    output logic                           xfer_done,
    output logic                           xfer_error,
    output logic [63:0]                    periph_req
);
    int unsigned cnt;
    logic        req_q;

    // memory answer; error is only meaningful with done, so it toggles otherwise
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            xfer_done <= 1'b0;
            xfer_error <= 1'b0;
        end else begin
            xfer_done <= 1'b0;
            xfer_error <= ~xfer_error;
            if (xfer_valid && !xfer_done) begin
                if (cnt >= (slow ? 3 : 0)) begin
                    xfer_done <= 1'b1;
                    xfer_error <= xfer_req.addr[31];
                    cnt <= 0;
                end else begin
                    cnt <= cnt + 1;
                end
            end
        end
    end

    // peripheral drops its request at the edge after an ack
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= 1'b0;
        end else begin
            req_q <= want && !periph_ack[PERIPHERAL_IDENTIFIER];
        end
    end
    assign periph_req = 64'(req_q) << PERIPHERAL_IDENTIFIER;
endmodule

// *** dv/peripheral_dma_unit_tb.sv ***
/*
 * Self-checking bench of the dma unit registers and transfer engine.
 * Assumes the far side model of dma_far_side.sv.
 */
`timescale 1ns/1ps
`define chk_eq(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module peripheral_dma_unit_tb;
    logic        clock = 0;
    logic        rst_n = 0;
    logic [11:0] adr = '0;
    logic        rd = 0;
    logic        wr = 0;
    logic [31:0] wd = '0;
    logic [31:0] rdata;
    logic        wq;
    logic [63:0] req;
    logic [63:0] ack;
    logic        xv;
    logic        done;
    logic        err;
    logic        irq;
    logic        want = 0;
    logic        slow = 0;
    logic [31:0] v;
    peripheral_dma_pkg::xfer_req_t xr;
    int          fail_count = 0;
    int          n_checks = 0;
    int          acks = 0;
    int          cyc = 0;

    peripheral_dma_unit peripheral_dma_unit_inst (.clock(clock), .rst_n(rst_n),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wq),
        .periph_req(req), .periph_event(16'h0000), .periph_ack(ack), .xfer_valid(xv),
        .xfer_req(xr), .xfer_done(done), .xfer_error(err), .irq(irq));
    dma_far_side dma_far_side_inst (.clock(clock), .rst_n(rst_n), .want(want),
        .slow(slow), .xfer_valid(xv), .xfer_req(xr), .periph_ack(ack),
        .xfer_done(done), .xfer_error(err), .periph_req(req));

    initial begin
        forever #25 clock = ~clock;
    end
    // acks seen by the peripheral; a hang is cut short here
    always @(posedge clock) begin
        if (ack[5] === 1'b1) acks++;
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one register access, held until waitrequest is seen low
    task automatic bus(input logic w, input int ch, input logic [5:0] o, input logic [31:0] d);
        @(posedge clock);
        adr <= 12'(ch * peripheral_dma_pkg::CHAN_STRIDE) + 12'(o);
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clock); while (wq !== 1'b0);
        v = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rchk(string nm, int ch, logic [5:0] o, logic [31:0] e);
        bus(0, ch, o, 0);
        `chk_eq(nm, e, v)
    endtask
    // selector, pointer, count, reload pair, mode
    task automatic setup(int ch, logic [31:0] p, c, ra, rc, m);
        bus(1, ch, 6'h04, 5);
        bus(1, ch, 6'h00, p);
        bus(1, ch, 6'h08, c);
        bus(1, ch, 6'h0C, ra);
        bus(1, ch, 6'h10, rc);
        bus(1, ch, 6'h18, m);
    endtask
    // watch the registered ack itself, so no race with the counter above
    task automatic wait_acks(int n);
        repeat (n) begin
            do @(posedge clock); while (ack[5] !== 1'b1);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rchk("pointer", 0, 6'h00, 0);
        rchk("selector3", 3, 6'h04, 3);
        rchk("status15", 15, 6'h1C, 0);
        rchk("command", 0, 6'h14, 0);
        rchk("unmapped", 0, 6'h3C, 0);
    endtask
    // two items, a reload, one more item, then nothing
    task automatic t_run();
        slow <= 1'b1;
        setup(0, 32'h100, 2, 32'h200, 1, 2);
        bus(1, 0, 6'h14, 1);
        want <= 1'b1;
        wait_acks(3);
        repeat (20) @(posedge clock);
        `chk_eq("acks", 3, acks)
        rchk("count", 0, 6'h08, 0);
        rchk("pointer", 0, 6'h00, 32'h204);
        rchk("reload cnt", 0, 6'h10, 0);
        rchk("flags", 0, 6'h2C, 3);
        rchk("enabled", 0, 6'h1C, 1);
        slow <= 1'b0;
    endtask
    task automatic t_cmd();
        bus(1, 0, 6'h14, 0);
        rchk("zero cmd", 0, 6'h1C, 1);
        bus(1, 0, 6'h14, 2);
        rchk("disabled", 0, 6'h1C, 0);
        bus(1, 0, 6'h08, 1);
        repeat (20) @(posedge clock);
        rchk("held", 0, 6'h08, 1);
        bus(1, 0, 6'h14, 1);
        wait_acks(1);
        rchk("resumed", 0, 6'h08, 0);
        rchk("step", 0, 6'h00, 32'h208);
    endtask
    // bad pointer, interrupt, clear, restart; channel 0 so the design checks see it
    task automatic t_err();
        want <= 1'b0;
        setup(0, 32'h8000_0000, 3, 0, 0, 2);
        bus(1, 0, 6'h20, 4);
        rchk("mask", 0, 6'h28, 4);
        bus(1, 0, 6'h14, 1);
        want <= 1'b1;
        do @(posedge clock); while (irq !== 1'b1);
        rchk("err flags", 0, 6'h2C, 5);
        rchk("stopped", 0, 6'h08, 3);
        rchk("irq set", 0, 6'h20, 0);
        bus(0, 0, 6'h30, 0);
        `chk_eq("event", 1'b1, v[2])
        bus(0, 0, 6'h30, 0);
        `chk_eq("event clr", 1'b0, v[2])
        `chk_eq("irq", 1'b0, irq)
        bus(1, 0, 6'h00, 32'h300);
        bus(1, 0, 6'h14, 32'h100);
        wait_acks(3);
        rchk("restart", 0, 6'h00, 32'h30C);
        bus(1, 0, 6'h24, 4);
        rchk("unmask", 0, 6'h28, 0);
        want <= 1'b0;
    endtask
    task automatic t_ring();
        setup(0, 0, 1, 32'h400, 1, 32'hA);
        bus(1, 0, 6'h14, 1);
        want <= 1'b1;
        wait_acks(1);
        want <= 1'b0;
        repeat (4) @(posedge clock);
        rchk("ring cnt", 0, 6'h10, 1);
        rchk("ring ptr", 0, 6'h00, 32'h400);
        rchk("ring tc", 0, 6'h08, 1);
        `chk_eq("pid", 8'h05, xr.peripheral_identifier)
        bus(1, 0, 6'h14, 2);
    endtask

    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_run();
        t_cmd();
        t_err();
        t_ring();
        test_done();
    end
endmodule

// *** verilog/peripheral_dma_pkg.sv ***
/*
 * Shared constants and types of the peripheral DMA channel register set:
 * register offsets inside a channel block, field positions, reset values,
 * the memory transfer request carrier and the engine states.
 * Assumes a 32-bit register bus with byte addresses and word-aligned registers.
 */
package peripheral_dma_pkg;

    // channel block layout
    localparam int unsigned  CHAN_STRIDE    = 'h40;
    localparam logic [11:0]  VERSION_OFFSET = 12'h834;
    localparam logic [5:0]   OFF_MPTR       = 6'h00;
    localparam logic [5:0]   OFF_PSEL       = 6'h04;
    localparam logic [5:0]   OFF_TCNT       = 6'h08;
    localparam logic [5:0]   OFF_RADDR      = 6'h0C;
    localparam logic [5:0]   OFF_RCNT       = 6'h10;
    localparam logic [5:0]   OFF_CMD        = 6'h14;
    localparam logic [5:0]   OFF_MODE       = 6'h18;
    localparam logic [5:0]   OFF_STATUS     = 6'h1C;
    localparam logic [5:0]   OFF_IRQ_SET    = 6'h20;
    localparam logic [5:0]   OFF_IRQ_CLR    = 6'h24;
    localparam logic [5:0]   OFF_IRQ_MASK   = 6'h28;
    localparam logic [5:0]   OFF_IRQ_FLAGS  = 6'h2C;
    localparam logic [5:0]   OFF_IRQ_EVENT  = 6'h30;

    // field positions
    localparam int unsigned  CMD_EN_BIT     = 0;
    localparam int unsigned  CMD_DIS_BIT    = 1;
    localparam int unsigned  CMD_ERROR_CLEAR_COMMAND_BIT   = 8;
    localparam int unsigned  MODE_SIZE_LSB  = 0;
    localparam int unsigned  MODE_ETRIG_BIT = 2;
    localparam int unsigned  MODE_RING_BIT  = 3;
    localparam int unsigned  STATUS_EN_BIT  = 0;
    localparam int unsigned  IRQ_RCZ_BIT    = 0;
    localparam int unsigned  IRQ_TRC_BIT    = 1;
    localparam int unsigned  IRQ_TRANSFER_ERROR_FLAG_BIT   = 2;
    localparam int unsigned  COUNT_W        = 16;
    localparam int unsigned  IRQ_W          = 3;

    // reset values
    localparam logic [31:0]  RESET_WORD     = 32'h0000_0000;
    localparam logic [15:0]  RESET_COUNT    = 16'h0000;
    localparam logic [1:0]   SIZE_WORD      = 2'h2;

    // one memory transfer handed to the bus engine
    typedef struct packed {
        logic [31:0] addr;
        logic [1:0]  size;
        logic [7:0]  peripheral_identifier;
        logic [3:0]  channel;
    } xfer_req_t;

    typedef enum logic [1:0] {ENG_IDLE, ENG_BUSY, ENG_GAP} engine_state_t;

endpackage

// *** verilog/peripheral_dma_unit.sv ***
/*
 * Peripheral DMA unit: per-channel register blocks behind an Avalon-MM slave,
 * a lowest-channel-first transfer engine and one level interrupt.
 * Assumes periph_req, periph_event, xfer_done and xfer_error come from logic
 * on the same clock; a peripheral drops its request at the edge after its ack.
 */
// Summary of operation
// - identical channel blocks at 0x040 stride
// - memory pointer holds next transfer address
// - selector picks request line and peripheral
// - counter loaded, then shows remaining items
// - counter zero, reload nonzero: copy reload address
// - reload counter copied, then reload registers cleared
// - reload count zero at zero: transfers stop
// - command register write-only, zero bits ignored
// - disable bit stops channel transfers
// - error-clear bit clears error, resumes channel
// - registers reset zero except selector, version, live flags
// - enable bit starts; status follows commands
// - ring mode keeps reload registers
// - bad access sets error, stops, interrupts
// - reload-zero and complete flags track counters
`timescale 1ns/1ps
module peripheral_dma_unit #(
    parameter int unsigned N_CHAN        = 16,
    parameter int unsigned PID_W         = 6,
    parameter logic [31:0] VERSION_VALUE = 32'h0000_0123  // arbitrary value
) (
    input  wire logic                             clock,
    input  wire logic                             rst_n,
    input  wire logic [11:0]                      avs_address,
    input  wire logic                             avs_read,
    input  wire logic                             avs_write,
    input  wire logic [31:0]                      avs_writedata,
    input  wire logic [3:0]                       avs_byteenable,
    output logic [31:0]                           avs_readdata,
    output logic                                  avs_waitrequest,
    input  wire logic [(1<<PID_W)-1:0]            periph_req,
    input  wire logic [N_CHAN-1:0]                periph_event,
    output logic [(1<<PID_W)-1:0]                 periph_ack,
    output logic                                  xfer_valid,
    output peripheral_dma_pkg::xfer_req_t         xfer_req,
    input  wire logic                             xfer_done,
    input  wire logic                             xfer_error,
    output logic                                  irq
);
    localparam int unsigned CH_W   = $clog2(N_CHAN);
    localparam logic [11:0] SPAN   = 12'(N_CHAN * peripheral_dma_pkg::CHAN_STRIDE);

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic [31:0]       mptr  [N_CHAN];
    logic [PID_W-1:0]  psel  [N_CHAN];
    logic [15:0]       tcnt  [N_CHAN];
    logic [31:0]       raddr [N_CHAN];
    logic [15:0]       rcnt  [N_CHAN];
    logic [3:0]        mode  [N_CHAN];
    logic [2:0]        mask  [N_CHAN];
    logic [2:0]        event_flags [N_CHAN];
    logic [2:0]        flags [N_CHAN];
    logic [N_CHAN-1:0] enabled;
    logic [N_CHAN-1:0] transfer_error_flag;
    logic [N_CHAN-1:0] want;
    logic [N_CHAN-1:0] reload;
    logic [N_CHAN-1:0] done_ok;
    logic [N_CHAN-1:0] done_err;
    logic [N_CHAN-1:0] irq_vec;
    logic [31:0]       rd_word;
    logic [31:0]       wmask;
    logic [31:0]       cmd_bits;
    logic              req_seen;
    logic              wr_acc;
    logic              rd_acc;
    logic              in_chan;
    logic [CH_W-1:0]   ch_sel;
    logic [5:0]        off;

    // accept edge is the one where the master sees waitrequest low
    assign req_seen = (avs_read | avs_write) & avs_waitrequest;
    assign wr_acc   = avs_write & ~avs_waitrequest;
    assign rd_acc   = avs_read & ~avs_waitrequest;
    assign in_chan  = avs_address < SPAN;
    assign ch_sel   = avs_address[6 +: CH_W];
    assign off      = avs_address[5:0];
    assign cmd_bits = wr_acc & in_chan & (off == peripheral_dma_pkg::OFF_CMD)
                    ? avs_writedata : peripheral_dma_pkg::RESET_WORD;
    assign wmask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // read mux; write-only and unmapped words answer zero
    always_comb begin
        rd_word = peripheral_dma_pkg::RESET_WORD;
        if (avs_address == peripheral_dma_pkg::VERSION_OFFSET) begin
            rd_word = VERSION_VALUE;
        end else if (in_chan) begin
            unique case (off)
                peripheral_dma_pkg::OFF_MPTR:      rd_word = mptr[ch_sel];
                peripheral_dma_pkg::OFF_PSEL:      rd_word = 32'(psel[ch_sel]);
                peripheral_dma_pkg::OFF_TCNT:      rd_word = 32'(tcnt[ch_sel]);
                peripheral_dma_pkg::OFF_RADDR:     rd_word = raddr[ch_sel];
                peripheral_dma_pkg::OFF_RCNT:      rd_word = 32'(rcnt[ch_sel]);
                peripheral_dma_pkg::OFF_MODE:      rd_word = 32'(mode[ch_sel]);
                peripheral_dma_pkg::OFF_STATUS:    rd_word = 32'(enabled[ch_sel]);
                peripheral_dma_pkg::OFF_IRQ_MASK:  rd_word = 32'(mask[ch_sel]);
                peripheral_dma_pkg::OFF_IRQ_FLAGS: rd_word = 32'(flags[ch_sel]);
                peripheral_dma_pkg::OFF_IRQ_EVENT: rd_word = 32'(event_flags[ch_sel]);
                default:                           rd_word = peripheral_dma_pkg::RESET_WORD;
            endcase
        end
    end

    // one wait cycle on every access; data captured while waitrequest is high
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= peripheral_dma_pkg::RESET_WORD;
        end else begin
            avs_waitrequest <= ~req_seen;
            if (req_seen) begin
                avs_readdata <= avs_read ? rd_word : peripheral_dma_pkg::RESET_WORD;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // channel register blocks

    for (genvar i = 0; i < N_CHAN; i++) begin : g_chan
        logic       hit;
        logic       w_mptr;
        logic       w_psel;
        logic       w_tcnt;
        logic       w_raddr;
        logic       w_rcnt;
        logic       w_mode;
        logic       ev_pending;
        logic [2:0] prev_lvl;
        logic [2:0] ev_set;
        logic [2:0] ev_clr;
        logic [2:0] size_step;
        logic       ring;
        logic       etrig;

        assign hit     = wr_acc & in_chan & (ch_sel == CH_W'(i));
        assign w_mptr  = hit & (off == peripheral_dma_pkg::OFF_MPTR);
        assign w_psel  = hit & (off == peripheral_dma_pkg::OFF_PSEL);
        assign w_tcnt  = hit & (off == peripheral_dma_pkg::OFF_TCNT);
        assign w_raddr = hit & (off == peripheral_dma_pkg::OFF_RADDR);
        assign w_rcnt  = hit & (off == peripheral_dma_pkg::OFF_RCNT);
        assign w_mode  = hit & (off == peripheral_dma_pkg::OFF_MODE);
        assign ring    = mode[i][peripheral_dma_pkg::MODE_RING_BIT];
        assign etrig   = mode[i][peripheral_dma_pkg::MODE_ETRIG_BIT];

        // reserved size code moves a word, same as size two
        assign size_step = (mode[i][1:0] == 2'h0) ? 3'h1 :
                           (mode[i][1:0] == 2'h1) ? 3'h2 : 3'h4;

        // reload only when no software write to the pointer or counter races it
        assign reload[i] = (tcnt[i] == peripheral_dma_pkg::RESET_COUNT)
                         & (rcnt[i] != peripheral_dma_pkg::RESET_COUNT)
                         & ~w_tcnt & ~w_mptr;

        // a channel asks for the engine only with work left and no error
        assign want[i] = enabled[i] & ~transfer_error_flag[i]
                       & (tcnt[i] != peripheral_dma_pkg::RESET_COUNT)
                       & periph_req[psel[i]]
                       & (~etrig | ev_pending);

        // live flags: reload-zero, complete, error
        assign flags[i][peripheral_dma_pkg::IRQ_RCZ_BIT]  =
            (rcnt[i] == peripheral_dma_pkg::RESET_COUNT);
        assign flags[i][peripheral_dma_pkg::IRQ_TRC_BIT]  =
            (rcnt[i] == peripheral_dma_pkg::RESET_COUNT)
            & (tcnt[i] == peripheral_dma_pkg::RESET_COUNT);
        assign flags[i][peripheral_dma_pkg::IRQ_TRANSFER_ERROR_FLAG_BIT] = transfer_error_flag[i];

        // sticky events: rising flag edges, cleared by reading them
        assign ev_set  = flags[i] & ~prev_lvl;
        assign ev_clr  = (rd_acc && in_chan && ch_sel == CH_W'(i)
                          && off == peripheral_dma_pkg::OFF_IRQ_EVENT) ? 3'h7 : 3'h0;
        assign irq_vec[i] = |(event_flags[i] & mask[i]);

        // pointer and counter: transfer step, then reload, then software
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                mptr[i] <= peripheral_dma_pkg::RESET_WORD;
                tcnt[i] <= peripheral_dma_pkg::RESET_COUNT;
            end else begin
                if (done_ok[i] && tcnt[i] != peripheral_dma_pkg::RESET_COUNT) begin
                    mptr[i] <= mptr[i] + 32'(size_step);
                    tcnt[i] <= tcnt[i] - 16'h0001;
                end
                if (reload[i]) begin
                    mptr[i] <= raddr[i];
                    tcnt[i] <= rcnt[i];
                end
                if (w_mptr) begin
                    mptr[i] <= (mptr[i] & ~wmask) | (avs_writedata & wmask);
                end
                if (w_tcnt) begin
                    tcnt[i] <= (tcnt[i] & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
                end
            end
        end

        // reload pair: cleared after reload unless ring mode
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                raddr[i] <= peripheral_dma_pkg::RESET_WORD;
                rcnt[i]  <= peripheral_dma_pkg::RESET_COUNT;
            end else begin
                if (reload[i] && !ring) begin
                    raddr[i] <= peripheral_dma_pkg::RESET_WORD;
                    rcnt[i]  <= peripheral_dma_pkg::RESET_COUNT;
                end
                if (w_raddr) begin
                    raddr[i] <= (raddr[i] & ~wmask) | (avs_writedata & wmask);
                end
                if (w_rcnt) begin
                    rcnt[i] <= (rcnt[i] & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
                end
            end
        end

        // selector, mode and interrupt mask
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                psel[i] <= PID_W'(i);
                mode[i] <= 4'h0;
                mask[i] <= 3'h0;
            end else begin
                if (w_psel && avs_byteenable[0]) begin
                    psel[i] <= avs_writedata[PID_W-1:0];
                end
                if (w_mode && avs_byteenable[0]) begin
                    mode[i] <= avs_writedata[3:0];
                end
                if (hit && off == peripheral_dma_pkg::OFF_IRQ_SET) begin
                    mask[i] <= mask[i] | avs_writedata[2:0];
                end
                if (hit && off == peripheral_dma_pkg::OFF_IRQ_CLR) begin
                    mask[i] <= mask[i] & ~avs_writedata[2:0];
                end
            end
        end

        // commands; only ones act, disable beats enable, a new error beats clear
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                enabled[i]     <= 1'b0;
                transfer_error_flag[i]        <= 1'b0;
                ev_pending     <= 1'b0;
                prev_lvl       <= 3'h3;
                event_flags[i] <= 3'h0;
            end else begin
                if (hit && cmd_bits[peripheral_dma_pkg::CMD_EN_BIT]) begin
                    enabled[i] <= 1'b1;
                end
                if (hit && cmd_bits[peripheral_dma_pkg::CMD_DIS_BIT]) begin
                    enabled[i] <= 1'b0;
                end
                transfer_error_flag[i] <= (transfer_error_flag[i] & ~(hit & cmd_bits[peripheral_dma_pkg::CMD_ERROR_CLEAR_COMMAND_BIT]))
                         | done_err[i];
                ev_pending     <= (ev_pending & ~done_ok[i]) | periph_event[i];
                prev_lvl       <= flags[i];
                event_flags[i] <= (event_flags[i] & ~ev_clr) | ev_set;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transfer engine, lowest channel first

    peripheral_dma_pkg::engine_state_t state;
    logic [CH_W-1:0]                   cur;
    logic [CH_W-1:0]                   pick;

    // priority encoder: the lowest wanting channel wins
    always_comb begin
        pick = '0;
        for (int k = N_CHAN - 1; k >= 0; k--) begin
            if (want[k]) begin
                pick = CH_W'(k);
            end
        end
    end

    for (genvar i = 0; i < N_CHAN; i++) begin : g_done
        assign done_ok[i]  = (state == peripheral_dma_pkg::ENG_BUSY) & xfer_done
                           & ~xfer_error & (cur == CH_W'(i));
        assign done_err[i] = (state == peripheral_dma_pkg::ENG_BUSY) & xfer_done
                           & xfer_error & (cur == CH_W'(i));
    end

    // the gap cycle lets the acked peripheral drop its request first
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state      <= peripheral_dma_pkg::ENG_IDLE;
            cur        <= '0;
            xfer_valid <= 1'b0;
            xfer_req   <= '0;
            periph_ack <= '0;
            irq        <= 1'b0;
        end else begin
            periph_ack <= '0;
            irq        <= |irq_vec;
            unique case (state)
                peripheral_dma_pkg::ENG_IDLE: begin
                    if (|want) begin
                        state      <= peripheral_dma_pkg::ENG_BUSY;
                        cur        <= pick;
                        xfer_valid <= 1'b1;
                        xfer_req   <= '{addr: mptr[pick], size: mode[pick][1:0],
                                        peripheral_identifier: 8'(psel[pick]), channel: 4'(pick)};
                    end
                end
                peripheral_dma_pkg::ENG_BUSY: begin
                    if (xfer_done) begin
                        state      <= peripheral_dma_pkg::ENG_GAP;
                        xfer_valid <= 1'b0;
                        periph_ack[psel[cur]] <= ~xfer_error;
                    end
                end
                peripheral_dma_pkg::ENG_GAP: begin
                    state <= peripheral_dma_pkg::ENG_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks on channel 0 and the bus

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic c0_hit;
    assign c0_hit = in_chan & (ch_sel == '0);

    AST_ENABLE_CMD: assert property (wr_acc && c0_hit && cmd_bits[0] && !cmd_bits[1]
        |=> enabled[0]) else $error("enable command ignored");
    AST_DISABLE_CMD: assert property (wr_acc && c0_hit && cmd_bits[1]
        |=> !enabled[0] && !want[0]) else $error("disable command ignored");
    AST_ERR_CLEAR: assert property (wr_acc && c0_hit && cmd_bits[8] && !done_err[0]
        |=> !transfer_error_flag[0]) else $error("error clear failed");
    AST_ERR_STOPS: assert property (done_err[0]
        |=> (transfer_error_flag[0] && !want[0]) [*2]) else $error("error did not stop channel");
    AST_COUNT_DOWN: assert property (done_ok[0] && tcnt[0] != 16'h0000 && !reload[0]
        && !(wr_acc && c0_hit) |=> tcnt[0] == $past(tcnt[0]) - 16'h0001)
        else $error("counter did not step down");
    AST_RELOAD_PTR: assert property (reload[0] && !(wr_acc && c0_hit)
        |=> mptr[0] == $past(raddr[0]) && tcnt[0] == $past(rcnt[0]))
        else $error("reload did not load pointer");
    AST_RELOAD_CLEAR: assert property (reload[0] && !mode[0][3] && !(wr_acc && c0_hit)
        |=> rcnt[0] == 16'h0000 && raddr[0] == 32'h0000_0000)
        else $error("reload pair not cleared");
    AST_RING_KEEP: assert property (reload[0] && mode[0][3] && !(wr_acc && c0_hit)
        |=> $stable(rcnt[0])) else $error("ring mode lost reload count");
    AST_IDLE_AT_ZERO: assert property (tcnt[0] == 16'h0000 && rcnt[0] == 16'h0000
        |-> !want[0] && flags[0][1]) else $error("transfer at zero count");
    AST_WO_READ_ZERO: assert property (req_seen && avs_read && c0_hit && off == 6'h14
        |=> avs_readdata == 32'h0000_0000) else $error("write-only word read nonzero");
    AST_BUS_ANSWER: assert property (req_seen |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing wrong");

    COV_RELOAD: cover property (reload[0] ##1 want[0]);
    COV_ERROR: cover property (done_err[0] ##[1:20] !transfer_error_flag[0]);
    COV_IRQ: cover property ($rose(irq));
    COV_RING: cover property (reload[0] && mode[0][3]);

endmodule
